//--- common/i2c_stat_pkg.sv
package i2c_stat_pkg;

    // register map, byte addresses on the plain register port
    localparam logic [2:0] OFF_CLOCK_SEL = 3'h0;
    localparam logic [2:0] OFF_TIMEOUT_SEL = 3'h1;
    localparam logic [2:0] OFF_ACTIVITY = 3'h2;
    localparam logic [2:0] OFF_BUFFER = 3'h3;
    localparam logic [2:0] OFF_ERROR = 3'h4;
    localparam logic [2:0] OFF_CONTROL = 3'h5;
    localparam logic [2:0] OFF_TX_HOLD = 3'h6;
    localparam logic [2:0] OFF_RX_HOLD = 3'h7;

    // activity_status fields
    localparam int ACT_IDLE_BIT = 7;
    localparam int ACT_TARGET_BIT = 6;
    localparam int ACT_CTRL_BIT = 5;
    localparam int ACT_DIR_BIT = 4;
    localparam int ACT_DATA_BIT = 3;

    // buffer_status fields
    localparam int BUF_TRANSMIT_WRITE_ERROR_BIT = 7;
    localparam int BUF_TRANSMIT_HOLDING_EMPTY_BIT = 5;
    localparam int BUF_RECEIVE_READ_ERROR_BIT = 3;
    localparam int BUF_FLUSH_BIT = 2;
    localparam int BUF_RECEIVE_HOLDING_FULL_BIT = 0;

    // error_flags_and_enables fields
    localparam int ERR_TO_BIT = 6;
    localparam int ERR_COL_BIT = 5;
    localparam int ERR_NACK_BIT = 4;
    localparam int ERR_TO_EN_BIT = 2;
    localparam int ERR_COL_EN_BIT = 1;
    localparam int ERR_NACK_EN_BIT = 0;

    // module_control fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_IDLE_LSB = 1;
    localparam int CTL_MODE_LSB = 3;

    // clock and timeout source codes
    localparam logic [3:0] CLK_LAST_CODE = 4'h9;
    localparam int CLK_SRC_COUNT = 10;
    localparam logic [2:0] TO_NONE_CODE = 3'h0;

    // bus-free times in module clock pulses
    localparam int IDLE_CNT_W = 7;
    localparam logic [6:0] IDLE_COUNT_8 = 7'h08;
    localparam logic [6:0] IDLE_COUNT_16 = 7'h10;
    localparam logic [6:0] IDLE_COUNT_32 = 7'h20;
    localparam logic [6:0] IDLE_COUNT_64 = 7'h40;

    // values after reset
    localparam logic [3:0] RST_CLOCK_SEL = 4'h0;
    localparam logic [2:0] RST_TIMEOUT_SEL = 3'h0;
    localparam logic [7:0] RST_CONTROL = 8'h00;
    localparam logic [7:0] RST_BYTE = 8'h00;

    typedef enum logic [1:0] {
        MODE_CONTROLLER = 2'b00,
        MODE_TARGET = 2'b01,
        MODE_MULTI = 2'b10,
        MODE_SPARE = 2'b11
    } mode_type;

endpackage : i2c_stat_pkg

//--- core/line_idle_detect.sv
`timescale 1ns/1ns
`default_nettype none
module line_idle_detect (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic tick,
    input wire logic clock_valid,
    input wire logic [1:0] idle_sel,
    output logic scl_level,
    output logic sda_level,
    output logic scl_rise,
    output logic line_idle
);
    // index 0 is scl, index 1 is sda
    logic [1:0] sync0_q, sync1_q, sync2_q;
    logic [1:0] level_q, level_d;
    logic rise_q, rise_d;
    logic [6:0] count_q, count_d;
    logic idle_q, idle_d;
    logic [6:0] limit;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_line
            // a change counts once stages two and three agree
            always_comb begin
                level_d[g] = level_q[g];
                if (sync1_q[g] == sync2_q[g]) begin
                    level_d[g] = sync2_q[g];
                end
            end
        end
    endgenerate

    always_comb begin
        limit = i2c_stat_pkg::IDLE_COUNT_8;
        case (idle_sel) // R23
            2'b01: limit = i2c_stat_pkg::IDLE_COUNT_16;
            2'b10: limit = i2c_stat_pkg::IDLE_COUNT_32;
            2'b11: limit = i2c_stat_pkg::IDLE_COUNT_64;
            default: limit = i2c_stat_pkg::IDLE_COUNT_8;
        endcase
        rise_d = level_d[0] & ~level_q[0];
        count_d = count_q;
        idle_d = 1'b0;
        if (!clock_valid || !(level_q[0] && level_q[1])) begin // R3 R4
            count_d = 7'h00;
        end else begin
            if (tick && (count_q < limit)) begin
                count_d = count_q + 7'h01;
            end
            idle_d = (count_d >= limit); // R3
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync0_q <= 2'b11;
            sync1_q <= 2'b11;
            sync2_q <= 2'b11;
            level_q <= 2'b11;
            rise_q <= 1'b0;
            count_q <= 7'h00;
            idle_q <= 1'b0;
        end else begin
            sync0_q <= {sda_pin, scl_pin};
            sync1_q <= sync0_q;
            sync2_q <= sync1_q;
            level_q <= level_d;
            rise_q <= rise_d;
            count_q <= count_d;
            idle_q <= idle_d;
        end
    end

    assign scl_level = level_q[0];
    assign sda_level = level_q[1];
    assign scl_rise = rise_q;
    assign line_idle = idle_q;
endmodule : line_idle_detect
`default_nettype wire

//--- core/i2c_status_core.sv
// Overview of operation
// R1: four-bit code picks module clock; reserved codes off
// R2: three-bit code picks timeout source; zero none
// R3: idle only after both lines high long enough
// R4: no valid clock source keeps idle cleared
// R5: target engaged after matching address byte
// R6: ten-bit high read needs earlier write sequence
// R7: restart, stop, timeout or collision clear target
// R8: controller engaged set by driven start
// R9: collision or shifted stop clears controller engaged
// R10: direction bit from last matching received address
// R11: data bit tells data versus address byte
// R12: writing full transmit buffer sets sticky error
// R13: transmit empty flag, cleared by write, resets set
// R14: reading empty receive buffer sets sticky error
// R15: receive full set on arrival, cleared by read
// R16: flush empties buffers, clears irq flags, reads zero
// R17: module disabled holds buffer flags at reset
// R18: pending buffer error forces not-acknowledge
// R19: buffer flags drive dma requests
// R20: released high but sampled low flags collision
// R21: not-ack flag from bus nack or errors
// R22: enabled error flags ored into error irq
// R23: bus-free time selectable 8 to 64 pulses
// R24: hardware flags stay set until written zero
`timescale 1ns/1ns
`default_nettype none
module i2c_status_core (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sda_sending,
    input wire logic sda_out_high,
    input wire logic [9:0] clk_src_tick,
    input wire logic [7:1] timeout_src,
    input wire logic match_7bit,
    input wire logic match_10_low,
    input wire logic match_10_high,
    input wire logic addr_rw,
    input wire logic byte_done,
    input wire logic byte_is_data,
    input wire logic rx_load,
    input wire logic [7:0] rx_data,
    input wire logic tx_take,
    input wire logic start_driven,
    input wire logic stop_shifted,
    input wire logic restart_seen,
    input wire logic stop_seen,
    input wire logic nack_seen,
    input wire logic overflow_set,
    input wire logic underflow_set,
    output logic module_tick,
    output logic scl_level,
    output logic sda_level,
    output logic [7:0] tx_data,
    output logic target_engaged,
    output logic controller_engaged,
    output logic force_nack,
    output logic collision_abort,
    output logic multi_match_retry,
    output logic timeout_stop_request,
    output logic irq_flags_clear,
    output logic tx_dma_request,
    output logic rx_dma_request,
    output logic module_error_irq
);
    logic [3:0] clk_sel_q, clk_sel_d;
    logic [2:0] to_sel_q, to_sel_d;
    logic [7:0] control_q, control_d;
    logic transmit_write_error_q, transmit_write_error_d, transmit_holding_empty_q, transmit_holding_empty_d, receive_read_error_q, receive_read_error_d, receive_holding_full_q, receive_holding_full_d;
    logic to_flag_q, to_flag_d, col_flag_q, col_flag_d;
    logic nack_flag_q, nack_flag_d;
    logic to_en_q, to_en_d, col_en_q, col_en_d, nack_en_q, nack_en_d;
    logic target_q, target_d, ctrl_q, ctrl_d;
    logic dir_q, dir_d, data_q, data_d, ten_write_q, ten_write_d;
    logic [7:0] tx_data_q, tx_data_d, rx_data_q, rx_data_d;
    logic [7:0] rdata_q, rdata_d;
    logic abort_q, abort_d, retry_q, retry_d, stop_req_q, stop_req_d;
    logic flush_q, flush_d, to_prev_q, to_prev_d;
    logic clock_valid, enable, target_mode, line_idle, scl_rise;
    logic to_level, to_event, col_event, transmit_write_error_set, receive_read_error_set, target_clear;
    i2c_stat_pkg::mode_type mode;

    function automatic logic clock_code_ok(input logic [3:0] code);
        clock_code_ok = (code <= i2c_stat_pkg::CLK_LAST_CODE);
    endfunction : clock_code_ok

    assign mode = i2c_stat_pkg::mode_type'(
        control_q[i2c_stat_pkg::CTL_MODE_LSB +: 2]);
    assign enable = control_q[i2c_stat_pkg::CTL_EN_BIT];
    assign target_mode = (mode == i2c_stat_pkg::MODE_TARGET);
    // the target mode runs on the system clock, the selection is bypassed
    assign clock_valid = target_mode | clock_code_ok(clk_sel_q); // R1 R4

    always_comb begin
        module_tick = 1'b0;
        if (target_mode) begin
            module_tick = 1'b1;
        end else if (clock_code_ok(clk_sel_q)) begin // R1
            module_tick = clk_src_tick[clk_sel_q];
        end
    end

    line_idle_detect u_idle (
        .ref_clk(ref_clk),
        .rst(rst),
        .scl_pin(scl_pin),
        .sda_pin(sda_pin),
        .tick(module_tick),
        .clock_valid(clock_valid),
        .idle_sel(control_q[i2c_stat_pkg::CTL_IDLE_LSB +: 2]),
        .scl_level(scl_level),
        .sda_level(sda_level),
        .scl_rise(scl_rise),
        .line_idle(line_idle)
    );

    always_comb begin
        to_level = 1'b0;
        if (to_sel_q != i2c_stat_pkg::TO_NONE_CODE) begin // R2
            to_level = timeout_src[to_sel_q];
        end
    end
    assign to_event = to_level & ~to_prev_q; // R2
    assign col_event = scl_rise & sda_sending & sda_out_high
        & ~sda_level; // R20
    assign target_clear = restart_seen | stop_seen | to_event
        | col_event; // R7

    always_comb begin
        clk_sel_d = clk_sel_q;
        to_sel_d = to_sel_q;
        control_d = control_q;
        transmit_write_error_d = transmit_write_error_q;
        transmit_holding_empty_d = transmit_holding_empty_q;
        receive_read_error_d = receive_read_error_q;
        receive_holding_full_d = receive_holding_full_q;
        to_flag_d = to_flag_q;
        col_flag_d = col_flag_q;
        nack_flag_d = nack_flag_q;
        to_en_d = to_en_q;
        col_en_d = col_en_q;
        nack_en_d = nack_en_q;
        target_d = target_q;
        ctrl_d = ctrl_q;
        dir_d = dir_q;
        data_d = data_q;
        ten_write_d = ten_write_q;
        tx_data_d = tx_data_q;
        rx_data_d = rx_data_q;
        rdata_d = 8'h00;
        flush_d = 1'b0;
        transmit_write_error_set = 1'b0;
        receive_read_error_set = 1'b0;
        to_prev_d = to_level;
        // software writes; flags are kept by a one and cleared by a zero
        if (reg_wr) begin
            if (reg_addr == i2c_stat_pkg::OFF_CLOCK_SEL) begin
                clk_sel_d = reg_wdata[3:0];
            end else if (reg_addr == i2c_stat_pkg::OFF_TIMEOUT_SEL) begin
                to_sel_d = reg_wdata[2:0];
            end else if (reg_addr == i2c_stat_pkg::OFF_BUFFER) begin
                transmit_write_error_d = transmit_write_error_q & reg_wdata[i2c_stat_pkg::BUF_TRANSMIT_WRITE_ERROR_BIT]; // R24
                receive_read_error_d = receive_read_error_q & reg_wdata[i2c_stat_pkg::BUF_RECEIVE_READ_ERROR_BIT]; // R24
                flush_d = reg_wdata[i2c_stat_pkg::BUF_FLUSH_BIT]; // R16
            end else if (reg_addr == i2c_stat_pkg::OFF_ERROR) begin
                to_flag_d = to_flag_q & reg_wdata[i2c_stat_pkg::ERR_TO_BIT];
                col_flag_d = col_flag_q & reg_wdata[i2c_stat_pkg::ERR_COL_BIT];
                nack_flag_d = nack_flag_q
                    & reg_wdata[i2c_stat_pkg::ERR_NACK_BIT]; // R24
                to_en_d = reg_wdata[i2c_stat_pkg::ERR_TO_EN_BIT];
                col_en_d = reg_wdata[i2c_stat_pkg::ERR_COL_EN_BIT];
                nack_en_d = reg_wdata[i2c_stat_pkg::ERR_NACK_EN_BIT];
            end else if (reg_addr == i2c_stat_pkg::OFF_CONTROL) begin
                control_d = reg_wdata;
            end else if (reg_addr == i2c_stat_pkg::OFF_TX_HOLD) begin
                if (!transmit_holding_empty_q) begin
                    transmit_write_error_set = 1'b1; // R12
                end else begin
                    tx_data_d = reg_wdata;
                    transmit_holding_empty_d = 1'b0; // R13
                end
            end
        end
        // reads; the receive holding buffer read has side effects
        if (reg_rd) begin
            if (reg_addr == i2c_stat_pkg::OFF_CLOCK_SEL) begin
                rdata_d = {4'h0, clk_sel_q};
            end else if (reg_addr == i2c_stat_pkg::OFF_TIMEOUT_SEL) begin
                rdata_d = {5'h00, to_sel_q};
            end else if (reg_addr == i2c_stat_pkg::OFF_ACTIVITY) begin
                rdata_d[i2c_stat_pkg::ACT_IDLE_BIT] = line_idle;
                rdata_d[i2c_stat_pkg::ACT_TARGET_BIT] = target_q;
                rdata_d[i2c_stat_pkg::ACT_CTRL_BIT] = ctrl_q;
                rdata_d[i2c_stat_pkg::ACT_DIR_BIT] = dir_q;
                rdata_d[i2c_stat_pkg::ACT_DATA_BIT] = data_q;
            end else if (reg_addr == i2c_stat_pkg::OFF_BUFFER) begin
                rdata_d[i2c_stat_pkg::BUF_TRANSMIT_WRITE_ERROR_BIT] = transmit_write_error_q;
                rdata_d[i2c_stat_pkg::BUF_TRANSMIT_HOLDING_EMPTY_BIT] = transmit_holding_empty_q;
                rdata_d[i2c_stat_pkg::BUF_RECEIVE_READ_ERROR_BIT] = receive_read_error_q;
                rdata_d[i2c_stat_pkg::BUF_RECEIVE_HOLDING_FULL_BIT] = receive_holding_full_q;
            end else if (reg_addr == i2c_stat_pkg::OFF_ERROR) begin
                rdata_d[i2c_stat_pkg::ERR_TO_BIT] = to_flag_q;
                rdata_d[i2c_stat_pkg::ERR_COL_BIT] = col_flag_q;
                rdata_d[i2c_stat_pkg::ERR_NACK_BIT] = nack_flag_q;
                rdata_d[i2c_stat_pkg::ERR_TO_EN_BIT] = to_en_q;
                rdata_d[i2c_stat_pkg::ERR_COL_EN_BIT] = col_en_q;
                rdata_d[i2c_stat_pkg::ERR_NACK_EN_BIT] = nack_en_q;
            end else if (reg_addr == i2c_stat_pkg::OFF_CONTROL) begin
                rdata_d = control_q;
            end else if (reg_addr == i2c_stat_pkg::OFF_TX_HOLD) begin
                rdata_d = tx_data_q;
            end else begin
                rdata_d = rx_data_q;
                if (!receive_holding_full_q) begin
                    receive_read_error_set = 1'b1; // R14
                end else begin
                    receive_holding_full_d = 1'b0; // R15
                end
            end
        end
        // hardware events on the buffers; new data wins over a read
        if (tx_take) begin
            transmit_holding_empty_d = 1'b1; // R13
        end
        if (rx_load) begin
            rx_data_d = rx_data;
            receive_holding_full_d = 1'b1; // R15
        end
        if (flush_d) begin
            transmit_holding_empty_d = 1'b1; // R16
            receive_holding_full_d = 1'b0;
        end
        if (!enable) begin
            transmit_holding_empty_d = 1'b1; // R17
            receive_holding_full_d = 1'b0;
        end
        // sticky flags: a set in the cycle of a clear wins
        if (transmit_write_error_set) begin
            transmit_write_error_d = 1'b1; // R12
        end
        if (receive_read_error_set) begin
            receive_read_error_d = 1'b1; // R14
        end
        if (to_event) begin
            to_flag_d = 1'b1; // R2
        end
        if (col_event) begin
            col_flag_d = 1'b1; // R20
        end
        if (((target_q | ctrl_q) & nack_seen) | transmit_write_error_set | receive_read_error_set
                | overflow_set | underflow_set) begin
            nack_flag_d = 1'b1; // R21
        end
        // ten-bit write sequence memory, kept across a repeated start
        if (stop_seen || to_event || col_event) begin
            ten_write_d = 1'b0;
        end else if (match_10_low) begin
            ten_write_d = 1'b1; // R6
        end
        if (target_clear) begin
            target_d = 1'b0; // R7
        end else if (match_7bit || match_10_low) begin
            target_d = 1'b1; // R5
        end else if (match_10_high && addr_rw && ten_write_q) begin
            target_d = 1'b1; // R6
        end
        if (col_event || stop_shifted) begin
            ctrl_d = 1'b0; // R9
        end else if (start_driven) begin
            ctrl_d = 1'b1; // R8
        end
        if (match_7bit || match_10_high) begin
            dir_d = addr_rw; // R10
        end
        if (byte_done) begin
            data_d = byte_is_data; // R11
        end
        abort_d = col_event & (mode != i2c_stat_pkg::MODE_MULTI); // R20
        retry_d = col_event & (mode == i2c_stat_pkg::MODE_MULTI); // R20
        // the controller finishes with a stop; that stop clears it
        stop_req_d = to_event & ctrl_q; // R9
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            clk_sel_q <= i2c_stat_pkg::RST_CLOCK_SEL;
            to_sel_q <= i2c_stat_pkg::RST_TIMEOUT_SEL;
            control_q <= i2c_stat_pkg::RST_CONTROL;
            transmit_write_error_q <= 1'b0;
            transmit_holding_empty_q <= 1'b1; // R13
            receive_read_error_q <= 1'b0;
            receive_holding_full_q <= 1'b0;
            to_flag_q <= 1'b0;
            col_flag_q <= 1'b0;
            nack_flag_q <= 1'b0;
            to_en_q <= 1'b0;
            col_en_q <= 1'b0;
            nack_en_q <= 1'b0;
            target_q <= 1'b0;
            ctrl_q <= 1'b0;
            dir_q <= 1'b0;
            data_q <= 1'b0;
            ten_write_q <= 1'b0;
            tx_data_q <= i2c_stat_pkg::RST_BYTE;
            rx_data_q <= i2c_stat_pkg::RST_BYTE;
            rdata_q <= i2c_stat_pkg::RST_BYTE;
            abort_q <= 1'b0;
            retry_q <= 1'b0;
            stop_req_q <= 1'b0;
            flush_q <= 1'b0;
            to_prev_q <= 1'b0;
        end else begin
            clk_sel_q <= clk_sel_d;
            to_sel_q <= to_sel_d;
            control_q <= control_d;
            transmit_write_error_q <= transmit_write_error_d;
            transmit_holding_empty_q <= transmit_holding_empty_d;
            receive_read_error_q <= receive_read_error_d;
            receive_holding_full_q <= receive_holding_full_d;
            to_flag_q <= to_flag_d;
            col_flag_q <= col_flag_d;
            nack_flag_q <= nack_flag_d;
            to_en_q <= to_en_d;
            col_en_q <= col_en_d;
            nack_en_q <= nack_en_d;
            target_q <= target_d;
            ctrl_q <= ctrl_d;
            dir_q <= dir_d;
            data_q <= data_d;
            ten_write_q <= ten_write_d;
            tx_data_q <= tx_data_d;
            rx_data_q <= rx_data_d;
            rdata_q <= rdata_d;
            abort_q <= abort_d;
            retry_q <= retry_d;
            stop_req_q <= stop_req_d;
            flush_q <= flush_d;
            to_prev_q <= to_prev_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign tx_data = tx_data_q;
    assign target_engaged = target_q;
    assign controller_engaged = ctrl_q;
    assign force_nack = transmit_write_error_q | receive_read_error_q; // R18
    assign collision_abort = abort_q;
    assign multi_match_retry = retry_q;
    assign timeout_stop_request = stop_req_q;
    assign irq_flags_clear = flush_q; // R16
    assign tx_dma_request = transmit_holding_empty_q; // R19
    assign rx_dma_request = receive_holding_full_q; // R19
    assign module_error_irq = (to_flag_q & to_en_q) | (col_flag_q & col_en_q)
        | (nack_flag_q & nack_en_q); // R22

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_reserved_clock;
        (clk_sel_q > i2c_stat_pkg::CLK_LAST_CODE) && !target_mode
            |-> !module_tick;
    endproperty
    a_reserved_clock: assert property (p_reserved_clock) // R1
        else $error("reserved clock code gave a tick");

    property p_timeout_flag;
        to_event |=> to_flag_q && $past(to_sel_q) != 3'h0;
    endproperty
    a_timeout_flag: assert property (p_timeout_flag) // R2
        else $error("timeout event did not set flag");

    property p_idle_lines;
        line_idle |-> $past(scl_level) && $past(sda_level);
    endproperty
    a_idle_lines: assert property (p_idle_lines) // R3
        else $error("idle reported with a line low");

    property p_idle_no_clock;
        !clock_valid |=> !line_idle;
    endproperty
    a_idle_no_clock: assert property (p_idle_no_clock) // R4
        else $error("idle set without clock source");

    property p_target_set;
        (match_7bit || match_10_low) && !target_clear |=> target_q;
    endproperty
    a_target_set: assert property (p_target_set) // R5
        else $error("address match did not engage target");

    property p_ten_high_guard;
        match_10_high && !ten_write_q && !target_q && !match_7bit
            && !match_10_low |=> !target_q;
    endproperty
    a_ten_high_guard: assert property (p_ten_high_guard) // R6
        else $error("ten-bit high read engaged target alone");

    property p_target_clear;
        restart_seen || stop_seen || col_event |=> !target_q;
    endproperty
    a_target_clear: assert property (p_target_clear) // R7
        else $error("target stayed engaged after clear");

    property p_ctrl_clear;
        stop_shifted || col_event |=> !ctrl_q;
    endproperty
    a_ctrl_clear: assert property (p_ctrl_clear) // R9
        else $error("controller stayed engaged");

    property p_direction;
        match_7bit |=> dir_q == $past(addr_rw);
    endproperty
    a_direction: assert property (p_direction) // R10
        else $error("direction bit not captured");

    property p_tx_write_error;
        reg_wr && reg_addr == i2c_stat_pkg::OFF_TX_HOLD && !transmit_holding_empty_q
            |=> transmit_write_error_q && force_nack && nack_flag_q;
    endproperty
    a_tx_write_error: assert property (p_tx_write_error) // R12
        else $error("write to full buffer missed error");

    property p_disabled_hold;
        !enable |=> transmit_holding_empty_q && !receive_holding_full_q;
    endproperty
    a_disabled_hold: assert property (p_disabled_hold) // R17
        else $error("buffer flags not held while disabled");

    property p_collision;
        col_event && mode != i2c_stat_pkg::MODE_MULTI
            |=> collision_abort && col_flag_q;
    endproperty
    a_collision: assert property (p_collision) // R20
        else $error("collision not flagged");

    c_target_session: cover property (match_7bit ##[1:200] stop_seen);
    c_ten_bit_read: cover property (match_10_low ##[1:200]
        (match_10_high && addr_rw && ten_write_q));
    c_error_irq: cover property (col_event ##1 module_error_irq);
endmodule : i2c_status_core
`default_nettype wire

//--- bench/bus_partner.sv
`timescale 1ns/1ns
`default_nettype none
module bus_partner (
    input wire logic ref_clk,
    input wire logic clk_run,
    input wire logic sda_low,
    output logic scl_pin,
    output logic sda_pin
);
    logic [1:0] div_q = 2'h0;
    // clock stands high outside frames; pull-ups keep both lines high
    always @(posedge ref_clk) begin
        div_q <= div_q + 2'h1;
        scl_pin <= clk_run ? div_q[1] : 1'b1;
    end
    assign sda_pin = ~sda_low;
endmodule : bus_partner
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, rd_seen = 0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, tx_data, rx_data = 8'h00;
    logic scl_pin, sda_pin, clk_run = 0, sda_low = 0, snd = 0;
    logic [9:0] ticks = 10'h000;
    logic [7:1] to_src = 7'h00;
    logic m7 = 0, rw = 0, rx_load = 0, stop_seen = 0, fnack, irq;
    logic m10l = 0, m10h = 0, rs = 0, sd = 0, ss = 0, bd = 0;
    logic tgt, ctl, txdma, rxdma;
    logic [7:0] exp_q[$];
    int n_mismatch = 0, compares = 0, cyc = 0, seed = 14454;
    bus_partner bp (.ref_clk(ref_clk), .clk_run(clk_run),
        .sda_low(sda_low), .scl_pin(scl_pin), .sda_pin(sda_pin));
    i2c_status_core DUT (.ref_clk(ref_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .scl_pin(scl_pin),
        .sda_pin(sda_pin), .sda_sending(snd), .sda_out_high(snd),
        .clk_src_tick(ticks), .timeout_src(to_src), .match_7bit(m7),
        .match_10_low(m10l), .match_10_high(m10h), .addr_rw(rw),
        .byte_done(bd), .byte_is_data(rw), .rx_load(rx_load),
        .rx_data(rx_data), .tx_take(1'b0), .start_driven(sd),
        .stop_shifted(ss), .restart_seen(rs), .stop_seen(stop_seen),
        .nack_seen(1'b0), .overflow_set(1'b0), .underflow_set(1'b0),
        .module_tick(), .scl_level(), .sda_level(), .tx_data(tx_data),
        .target_engaged(tgt), .controller_engaged(ctl), .force_nack(fnack),
        .collision_abort(), .multi_match_retry(),
        .timeout_stop_request(), .irq_flags_clear(), .tx_dma_request(txdma),
        .rx_dma_request(rxdma), .module_error_irq(irq));
    initial forever #20 ref_clk = ~ref_clk;
    task conclude;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : conclude
    task check(input logic [7:0] seen, input logic [7:0] e,
        input string what);
        compares++;
        if (seen !== e) begin
            n_mismatch++;
            $display("[FAIL] %s exp %h seen %h", what, e, seen);
        end
    endtask : check
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1;
        @(posedge ref_clk);
        reg_wr <= 0;
    endtask : wr
    task rd(input logic [2:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge ref_clk);
        reg_addr <= a; reg_rd <= 1;
        @(posedge ref_clk);
        reg_rd <= 0;
    endtask : rd
    always @(posedge ref_clk) begin
        cyc++;
        ticks <= 10'($random(seed));
        if (rd_seen) check(reg_rdata, exp_q.pop_front(), "reg_rdata");
        rd_seen <= reg_rd;
        if (cyc > 5000) begin
            n_mismatch++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        rd(3'h3, 8'h20);
        wr(3'h5, 8'h01);
        repeat (60) @(posedge ref_clk);
        rd(3'h2, 8'h80);
        wr(3'h0, 8'h0a);
        repeat (6) @(posedge ref_clk);
        rd(3'h2, 8'h00);
        wr(3'h0, 8'h00);
        wr(3'h6, 8'ha5);
        wr(3'h6, 8'h3c);
        rd(3'h3, 8'h80);
        check({7'h0, fnack}, 8'h01, "force_nack");
        check(tx_data, 8'ha5, "tx_data");
        rd(3'h7, 8'h00);
        rd(3'h3, 8'h88);
        rd(3'h4, 8'h10);
        wr(3'h4, 8'h11);
        @(negedge ref_clk) check({7'h0, irq}, 8'h01, "error_irq");
        wr(3'h3, 8'h04);
        rd(3'h3, 8'h20);
        rx_data <= 8'($random(seed));
        rx_load <= 1;
        @(posedge ref_clk) rx_load <= 0;
        rd(3'h3, 8'h21);
        @(negedge ref_clk) check({6'h0, txdma, rxdma}, 8'h03, "dma");
        rd(3'h7, rx_data);
        rd(3'h3, 8'h20);
        rw <= 1; m7 <= 1;
        @(posedge ref_clk) m7 <= 0;
        rd(3'h2, 8'hd0);
        stop_seen <= 1;
        @(posedge ref_clk) stop_seen <= 0;
        rd(3'h2, 8'h90);
        m10h <= 1;
        @(posedge ref_clk) m10h <= 0;
        rd(3'h2, 8'h90);
        rw <= 0; m10l <= 1;
        @(posedge ref_clk) m10l <= 0;
        rs <= 1;
        @(posedge ref_clk) rs <= 0;
        rw <= 1; m10h <= 1;
        @(posedge ref_clk) m10h <= 0;
        rd(3'h2, 8'hd0);
        sd <= 1; bd <= 1;
        @(posedge ref_clk) sd <= 0;
        bd <= 0;
        rd(3'h2, 8'hf8);
        ss <= 1;
        @(posedge ref_clk) ss <= 0;
        @(negedge ref_clk) check({6'h0, tgt, ctl}, 8'h02, "engaged");
        rd(3'h2, 8'hd8);
        wr(3'h4, 8'h00);
        wr(3'h1, 8'h01);
        to_src[1] <= 1;
        rd(3'h4, 8'h40);
        snd <= 1; sda_low <= 1; clk_run <= 1;
        repeat (16) @(posedge ref_clk);
        clk_run <= 0; snd <= 0; sda_low <= 0;
        rd(3'h4, 8'h60);
        repeat (3) @(posedge ref_clk);
        conclude();
    end
endmodule : tb
`default_nettype wire
